// *** hdl/otp_pkg.sv ***
// Package for the option timer and prescaler block: register indices, field
// positions, reset values and the shared carrier types.
// Assumes a plain register port with byte-wide data and a small index address.
package otp_pkg;

    // Register indices on the plain register port.
    localparam logic [1:0] OTP_ADDR_OPTION = 2'h0;
    localparam logic [1:0] OTP_ADDR_COUNT  = 2'h1;
    localparam logic [1:0] OTP_ADDR_IRQ    = 2'h2;
    localparam logic [1:0] OTP_ADDR_SENSE  = 2'h3;

    // Option register field positions.
    localparam int OTP_OPT_PULLUP_DIS = 7;
    localparam int OTP_OPT_IRQ_EDGE   = 6;
    localparam int OTP_OPT_CLK_SRC    = 5;
    localparam int OTP_OPT_SRC_EDGE   = 4;
    localparam int OTP_OPT_PS_ASSIGN  = 3;
    localparam int OTP_OPT_RATE_HI    = 2;

    // Interrupt control field positions.
    localparam int OTP_IRQ_GLOBAL_EN  = 7;
    localparam int OTP_IRQ_PERIPH_EN  = 6;
    localparam int OTP_IRQ_TMR_EN     = 5;
    localparam int OTP_IRQ_EXT_EN     = 4;
    localparam int OTP_IRQ_PORT_EN    = 3;
    localparam int OTP_IRQ_TMR_FLAG   = 2;
    localparam int OTP_IRQ_EXT_FLAG   = 1;
    localparam int OTP_IRQ_PORT_FLAG  = 0;

    // Sensing control: bit 0 picks the sensing oscillator as external source.
    localparam int OTP_SNS_EXT_PICK   = 0;
    localparam logic [7:0] OTP_SNS_MASK = 8'h8d;

    // Reset values.
    localparam logic [7:0] OTP_OPTION_RESET = 8'hff;
    localparam logic [7:0] OTP_IRQ_RESET    = 8'h00;
    localparam logic [7:0] OTP_SENSE_RESET  = 8'h00;
    localparam logic [7:0] OTP_COUNT_RESET  = 8'h00;

    // Register port request.
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } otp_req_t;

    // Pins sampled from outside the clock domain.
    typedef struct packed {
        logic       count_pin;
        logic       sense_osc;
        logic       ext_irq_pin;
        logic       sleep;
    } otp_pins_t;

endpackage

// *** hdl/otp_timer.sv ***
// Option control, 8-bit timer and shared prescaler with watchdog tick output.
// Assumes pins arrive asynchronously and the register master follows the
// one-cycle strobe protocol with read data returned the cycle after.
//
// How it works
// RL1 - A set pull-up disable bit turns all port-B pull-ups off, otherwise each follows its latch.
// RL2 - The edge select bit picks rising (1) or falling (0) external interrupt edge to set its flag.
// RL3 - The clock source bit counts external pin or sensing oscillator edges, else the instruction clock.
// RL4 - With the prescaler on the timer, rate codes 0 to 7 divide by 2 up to 256.
// RL5 - With the prescaler on the watchdog, rate codes 0 to 7 divide by 1 up to 128.
// RL6 - Every reset loads the option register with all ones.
// RL7 - The timer does not count while the device sleeps.
// RL8 - Interrupt control keeps timer enable in bit 5 and overflow flag in bit 2, both reset to zero.
// RL9 - The source edge bit counts falling pin edges when set and rising edges when clear.
// RL10 - Prescaler assign set routes the prescaler to the watchdog, clear to the timer.
`timescale 1ns/1ns

module otp_timer #(
    parameter int QUARTER = 4
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire otp_pkg::otp_req_t  req,
    input  wire otp_pkg::otp_pins_t pins,
    input  wire logic               wdt_tick_in,
    input  wire logic [7:0]         port_latch,
    output logic [7:0]              rdata,
    output logic [7:0]              pullup_en,
    output logic                    wdt_tick,
    output logic                    irq
);
    import otp_pkg::*;

    // Elaboration check: the phase counter is eight bits wide, so the divider
    // has to fit in it and cannot be zero.
    if (QUARTER < 1 || QUARTER > 255) begin
        $error("QUARTER out of range");
    end

    typedef struct packed {
        logic [7:0] option;
        logic [7:0] count;
        logic [7:0] irqc;
        logic [7:0] sense;
        logic [7:0] prescale;
        logic [7:0] quarter;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] last;
        logic       wdt_s1;
        logic       wdt_s2;
        logic       wdt_last;
        logic [7:0] rdata;
        logic [7:0] pullup_en;
        logic       wdt_tick;
        logic       irq;
    } otp_state_t;

    otp_state_t st;
    otp_state_t next_st;

    // Terminal count of the prescaler for a rate code; the watchdog side is half.
    function automatic logic [7:0] rate_mask(input logic [2:0] code, input logic to_wdt);
        logic [8:0] full;
        full = 9'h002 << code;
        rate_mask = to_wdt ? 8'(full[8:1] - 8'h01) : 8'(full - 9'h001);
    endfunction

    // Whole next state in one place; synchronisers are read only through sync2.
    always_comb begin
        logic       src_tick;
        logic       ext_edge;
        logic       pin_now;
        logic       pin_was;
        logic       inc;
        logic       wdt_edge;
        logic       set_tmr;
        logic       set_ext;
        logic [7:0] mask;
        // Every local starts from a known value so no path leaves one unset.
        src_tick = 1'b0;
        ext_edge = 1'b0;
        pin_now  = 1'b0;
        pin_was  = 1'b0;
        inc      = 1'b0;
        wdt_edge = 1'b0;
        set_tmr  = 1'b0;
        set_ext  = 1'b0;
        mask     = 8'h00;
        next_st = st;
        next_st.sync1 = {pins.count_pin, pins.sense_osc, pins.ext_irq_pin, pins.sleep};
        next_st.sync2 = st.sync1;
        next_st.last  = st.sync2;
        next_st.wdt_s1 = wdt_tick_in;
        next_st.wdt_s2 = st.wdt_s1;
        next_st.wdt_last = st.wdt_s2;
        next_st.wdt_tick = 1'b0;

        // External source is the pin or the sensing oscillator.
        pin_now = st.sense[OTP_SNS_EXT_PICK] ? st.sync2[2] : st.sync2[3];
        pin_was = st.sense[OTP_SNS_EXT_PICK] ? st.last[2] : st.last[3];
        ext_edge = st.option[OTP_OPT_SRC_EDGE] ? (pin_was & ~pin_now)   // RL9
                                               : (~pin_was & pin_now);
        // Instruction clock is the system clock divided by QUARTER, four by default.
        next_st.quarter = (st.quarter == 8'(QUARTER - 1)) ? 8'h00 : 8'(st.quarter + 8'h01);
        src_tick = st.option[OTP_OPT_CLK_SRC] ? ext_edge                   // RL3
                                              : (st.quarter == 8'h00);
        // Sleep stops the timer source only; the watchdog side keeps its own tick.
        if (st.sync2[0]) begin
            src_tick = 1'b0;                                               // RL7
        end

        // Shared prescaler: clocked by the timer source or the watchdog tick.
        wdt_edge = st.wdt_s2 & ~st.wdt_last;
        // A rate change does not clear the prescaler; the compare below lets an
        // over-range phase wrap on the next tick instead of running on to 255.
        mask = rate_mask(st.option[OTP_OPT_RATE_HI:0], st.option[OTP_OPT_PS_ASSIGN]);
        inc = 1'b0;
        if (st.option[OTP_OPT_PS_ASSIGN]) begin                            // RL10
            inc = src_tick;
            if (wdt_edge) begin                                            // RL5
                if (st.prescale >= mask) begin
                    next_st.prescale = 8'h00;
                    next_st.wdt_tick = 1'b1;
                end else begin
                    next_st.prescale = 8'(st.prescale + 8'h01);
                end
            end
        end else begin
            next_st.wdt_tick = wdt_edge;
            if (src_tick) begin                                            // RL4
                if (st.prescale >= mask) begin
                    next_st.prescale = 8'h00;
                    inc = 1'b1;
                end else begin
                    next_st.prescale = 8'(st.prescale + 8'h01);
                end
            end
        end

        // Timer count; the step from ff to 00 raises the timer flag.
        set_tmr = inc && st.count == 8'hff;
        if (inc) begin
            next_st.count = 8'(st.count + 8'h01);
        end

        // External interrupt edge on the synchronised pin.
        set_ext = st.option[OTP_OPT_IRQ_EDGE] ? (st.sync2[1] & ~st.last[1])  // RL2
                                              : (~st.sync2[1] & st.last[1]);

        // Register writes; hardware flag sets win over a software clear.
        // A count write also clears the prescaler so the next period starts whole.
        if (req.wr) begin
            if (req.addr == OTP_ADDR_OPTION) begin
                next_st.option = req.wdata;
            end else if (req.addr == OTP_ADDR_COUNT) begin
                next_st.count = req.wdata;
                next_st.prescale = 8'h00;
            end else if (req.addr == OTP_ADDR_IRQ) begin
                next_st.irqc = req.wdata;
            end else if (req.addr == OTP_ADDR_SENSE) begin
                next_st.sense = req.wdata & OTP_SNS_MASK;
            end
        end
        if (set_tmr) begin
            next_st.irqc[OTP_IRQ_TMR_FLAG] = 1'b1;                         // RL8
        end
        if (set_ext) begin
            next_st.irqc[OTP_IRQ_EXT_FLAG] = 1'b1;
        end

        // Read data stands the cycle after the read strobe only.
        next_st.rdata = 8'h00;
        if (req.rd) begin
            if (req.addr == OTP_ADDR_OPTION) begin
                next_st.rdata = st.option;
            end else if (req.addr == OTP_ADDR_COUNT) begin
                next_st.rdata = st.count;
            end else if (req.addr == OTP_ADDR_IRQ) begin
                next_st.rdata = st.irqc;
            end else begin
                next_st.rdata = st.sense;
            end
        end

        // Registered outputs: pull-up enables lag the port latch by one cycle, and
        // the request line is a plain level that follows enables and flags.
        next_st.pullup_en = st.option[OTP_OPT_PULLUP_DIS] ? 8'h00 : port_latch; // RL1
        next_st.irq = st.irqc[OTP_IRQ_GLOBAL_EN] &
                      ((st.irqc[OTP_IRQ_TMR_EN] & st.irqc[OTP_IRQ_TMR_FLAG]) |
                       (st.irqc[OTP_IRQ_EXT_EN] & st.irqc[OTP_IRQ_EXT_FLAG]) |
                       (st.irqc[OTP_IRQ_PORT_EN] & st.irqc[OTP_IRQ_PORT_FLAG]));

        if (!resetn) begin
            next_st = '0;
            next_st.option = OTP_OPTION_RESET;                             // RL6
            next_st.irqc = OTP_IRQ_RESET;                                  // RL8
            next_st.sense = OTP_SENSE_RESET;
            next_st.count = OTP_COUNT_RESET;
            // The edge history keeps following the pins through reset, so a pin that
            // idles high is not taken for a fresh edge once reset lifts.
            next_st.sync1    = {pins.count_pin, pins.sense_osc, pins.ext_irq_pin, pins.sleep};
            next_st.sync2    = st.sync1;
            next_st.last     = st.sync2;
            next_st.wdt_s1   = wdt_tick_in;
            next_st.wdt_s2   = st.wdt_s1;
            next_st.wdt_last = st.wdt_s2;
        end
    end

    // Single state register; reset is folded into the next-state logic.
    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // Every output comes straight from the state register.
    assign rdata     = st.rdata;
    assign pullup_en = st.pullup_en;
    assign wdt_tick  = st.wdt_tick;
    assign irq       = st.irq;

endmodule

// *** dv/otp_timer_properties.sv ***
// Checker for the option timer ports.
// Assumes one-cycle register strobes and a synchronous active-low reset.
`timescale 1ns/1ns
module otp_timer_properties #(parameter int QUARTER = 4) (
    input wire logic               clk,
    input wire logic               resetn,
    input wire otp_pkg::otp_req_t  req,
    input wire otp_pkg::otp_pins_t pins,
    input wire logic               wdt_tick_in,
    input wire logic [7:0]         port_latch,
    input wire logic [7:0]         rdata,
    input wire logic [7:0]         pullup_en,
    input wire logic               wdt_tick,
    input wire logic               irq
);
    import otp_pkg::*;
    logic [7:0] opt_m;
    logic [7:0] ie_m;
    logic       en_ok;
    // Copies of bits that only software writes, so they can be tracked exactly.
    always_ff @(posedge clk) begin
        opt_m <= !resetn ? 8'hff : (req.wr && req.addr == OTP_ADDR_OPTION) ? req.wdata : opt_m;
        ie_m  <= !resetn ? 8'h00 : (req.wr && req.addr == OTP_ADDR_IRQ) ? req.wdata : ie_m;
    end
    // Either timing of the registered request line is accepted.
    assign en_ok = ie_m[7] && (ie_m[5:3] != 3'h0);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_pu_off; opt_m[7] && $past(opt_m[7]) |-> pullup_en == 8'h00; endproperty
    a_pu_off: assert property (p_pu_off) else $error("pull-ups on while disabled");
    property p_pu_on; !opt_m[7] && !$past(opt_m[7]) |-> pullup_en == $past(port_latch); endproperty
    a_pu_on: assert property (p_pu_on) else $error("pull-ups differ from latch");
    property p_rd_idle; !$past(req.rd) |-> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_rd_opt; req.rd && req.addr == OTP_ADDR_OPTION |=> rdata == opt_m; endproperty
    a_rd_opt: assert property (p_rd_opt) else $error("option read mismatch");
    property p_rst; $rose(resetn) |-> !irq && !wdt_tick && pullup_en == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset level");
    property p_irq; irq |-> en_ok || $past(en_ok); endproperty
    a_irq: assert property (p_irq) else $error("request without enables");
    property p_wdt_pulse; wdt_tick |=> !wdt_tick; endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog tick too long");
    property p_wdt_quiet; $stable(wdt_tick_in) [*8] |-> !wdt_tick; endproperty
    a_wdt_quiet: assert property (p_wdt_quiet) else $error("watchdog tick without input");
    c_irq: cover property (irq);
    c_wdt: cover property (wdt_tick);
    c_pu: cover property (pullup_en != 8'h00);
endmodule

bind otp_timer otp_timer_properties #(.QUARTER(QUARTER)) i_props (
    .clk(clk), .resetn(resetn), .req(req), .pins(pins), .wdt_tick_in(wdt_tick_in),
    .port_latch(port_latch), .rdata(rdata), .pullup_en(pullup_en), .wdt_tick(wdt_tick),
    .irq(irq));

// *** dv/otp_count_src.sv ***
// Model of the external count pin and the sensing oscillator.
// Assumes step pulses from the bench last one clock.
`timescale 1ns/1ns
module otp_count_src #(parameter int HALF = 5) (
    input  wire logic clk,
    input  wire logic step,
    output logic      count_pin,
    output logic      sense_osc
);
    int n = 0;
    initial count_pin = 1'b0;
    initial sense_osc = 1'b0;
    // The pin moves only on request; the oscillator runs free, as the real one does.
    always @(posedge clk) begin
        count_pin <= count_pin ^ step;
        n <= (n == HALF - 1) ? 0 : n + 1;
        sense_osc <= (n == HALF - 1) ? ~sense_osc : sense_osc;
    end
endmodule

// *** dv/otp_timer_tb.sv ***
// Bench for the option timer: registers, rates, edges, sleep and request line.
// Assumes the checker is bound in and the partner model drives the count pins.
`timescale 1ns/1ns
module otp_timer_tb;
    import otp_pkg::*;
    localparam int Q = 4;
    logic clk = 0, resetn = 0, wdt_tick_in = 0, wdt_run = 0, step = 0, ext = 0, slp = 0;
    logic [7:0] rdata, pullup_en, v, port_latch = 8'h5a;
    logic wdt_tick, irq, pin, osc;
    otp_req_t req = '0;
    otp_pins_t pins;
    int n_errors = 0, tests_run = 0, n_wdt = 0, dw;
    assign pins = '{count_pin: pin, sense_osc: osc, ext_irq_pin: ext, sleep: slp};
    otp_timer #(.QUARTER(Q)) i_dut (.clk(clk), .resetn(resetn), .req(req), .pins(pins),
        .wdt_tick_in(wdt_tick_in), .port_latch(port_latch), .rdata(rdata),
        .pullup_en(pullup_en), .wdt_tick(wdt_tick), .irq(irq));
    otp_count_src #(.HALF(5)) i_src (.clk(clk), .step(step), .count_pin(pin), .sense_osc(osc));
    always #20 clk = ~clk;
    // Base tick rises every other cycle while enabled; output ticks are counted.
    always @(posedge clk) begin
        wdt_tick_in <= wdt_tick_in ^ wdt_run;
        n_wdt <= n_wdt + int'(wdt_tick);
    end
    task automatic chk(input string s, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rc(input logic [1:0] a, input string s, input logic [7:0] x);
        logic [7:0] d;
        rd(a, d);
        chk(s, 16'(x), 16'(d));
    endtask
    // Count reads d cycles apart; the periodic tick makes the difference exact.
    task automatic meas(input int d, output logic [7:0] dt);
        logic [7:0] a;
        int w;
        rd(OTP_ADDR_COUNT, a);
        w = n_wdt;
        repeat (d - 2) @(posedge clk);
        rd(OTP_ADDR_COUNT, dt);
        dt = dt - a;
        dw = n_wdt - w;
    endtask
    task automatic conclude;
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        n_errors++;
        conclude;
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rc(OTP_ADDR_OPTION, "option", 8'hff);
        rc(OTP_ADDR_IRQ, "irqc", 8'h00);
        wr(OTP_ADDR_OPTION, 8'h00);
        repeat (3) @(negedge clk);
        chk("pullup", 16'(8'h5a), 16'(pullup_en));
        @(posedge clk);
        port_latch <= 8'ha5;
        repeat (3) @(negedge clk);
        chk("pullup", 16'(8'ha5), 16'(pullup_en));
        wr(OTP_ADDR_OPTION, 8'h80);
        repeat (3) @(negedge clk);
        chk("pullup", 16'(8'h00), 16'(pullup_en));
        wr(OTP_ADDR_SENSE, 8'hff);
        rc(OTP_ADDR_SENSE, "sense", OTP_SNS_MASK);
        wdt_run <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(OTP_ADDR_OPTION, 8'(c));
            meas(Q * 256, v);
            chk("timer", 16'(128 >> c), 16'(v));
            chk("wdt", 16'(512), 16'(dw));
            wr(OTP_ADDR_OPTION, 8'(8 + c));
            meas(Q * 192, v);
            chk("timer", 16'(192), 16'(v));
            chk("wdt", 16'(384 >> c), 16'(dw));
        end
        wdt_run <= 1'b0;
        wr(OTP_ADDR_SENSE, 8'h01);
        wr(OTP_ADDR_OPTION, 8'h28);
        meas(1000, v);
        chk("osc", 16'(100), 16'(v));
        wr(OTP_ADDR_SENSE, 8'h00);
        wr(OTP_ADDR_OPTION, 8'h08);
        slp <= 1'b1;
        repeat (4) @(posedge clk);
        meas(400, v);
        chk("sleep", 16'(0), 16'(v));
        slp <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            wr(OTP_ADDR_OPTION, e ? 8'h38 : 8'h28);
            wr(OTP_ADDR_COUNT, 8'h00);
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            repeat (8) @(posedge clk);
            rc(OTP_ADDR_COUNT, "rise", e ? 8'h00 : 8'h01);
            @(posedge clk);
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            repeat (8) @(posedge clk);
            rc(OTP_ADDR_COUNT, "fall", 8'h01);
            wr(OTP_ADDR_OPTION, e ? 8'h68 : 8'h28);
            wr(OTP_ADDR_IRQ, 8'h00);
            ext <= 1'b1;
            repeat (8) @(posedge clk);
            rc(OTP_ADDR_IRQ, "edge_up", e ? 8'h02 : 8'h00);
            @(posedge clk);
            ext <= 1'b0;
            repeat (8) @(posedge clk);
            rc(OTP_ADDR_IRQ, "edge_down", 8'h02);
        end
        wr(OTP_ADDR_OPTION, 8'h08);
        wr(OTP_ADDR_IRQ, 8'ha0);
        wr(OTP_ADDR_COUNT, 8'hff);
        repeat (12) @(posedge clk);
        rc(OTP_ADDR_IRQ, "overflow", 8'ha4);
        chk("irq", 16'(1), 16'(irq));
        wr(OTP_ADDR_IRQ, 8'ha0);
        repeat (3) @(negedge clk);
        chk("irq", 16'(0), 16'(irq));
        // A second reset mid-run must bring option and interrupt control back.
        wr(OTP_ADDR_OPTION, 8'h00);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rc(OTP_ADDR_OPTION, "option", 8'hff);
        rc(OTP_ADDR_IRQ, "irqc", 8'h00);
        chk("pullup", 16'(8'h00), 16'(pullup_en));
        conclude;
    end
endmodule
